// *** logic/aux_func_params.svh ***
// Notes on behaviour
// - New on/off times stay pending until the on-time upper byte is written.
// - Phases count oscillator ticks; 1 us ticks give about 65.5 ms maximum.
// - Off-time is sixteen bits from a low and a high byte register.
// - Config bit 2 ANDs internal waveform with the column 6 pin input.
// - Mode bit 1: 0 continuous, 1 one pulse; one-shot clears enable bit 0.
// - External clock divided by field value plus one; 0 passes, 31 divides by 32.
// - Divider bit 6 inverts the divided clock output.
// - The external clock is divided only while divider enable bit 0 is set.
// - Block 1 select: off, AND, OR, XOR, flop, input A, B, C.
// - Block 2 select decodes exactly as block 1.
// - Block 1 config bits 3, 4, 5 invert inputs A, B, C.
// - Block 1 config bit 6 inverts block 1 output, except at select 0 where it stays low.
// - Block 2 config bits 3, 4, 5 invert inputs A, B, C.
// - Block 2 config bit 6 inverts block 2 output, except at select 0 where it stays low.
// - Block 2 bit 7 feeds block 1 output into block 2 input A.
// - While chained, the row 0 pin is not used as block 2 input.
// - Flop control bit 1 sets, bit 0 clears block 1 flop; zeros ignored.
// - Flop control bit 3 sets, bit 2 clears block 2 flop; zeros ignored.
`ifndef AUX_FUNC_PARAMS_SVH
`define AUX_FUNC_PARAMS_SVH
`define ADDR_OFF_LOW      8'h3e
`define ADDR_OFF_HIGH     8'h3f
`define ADDR_ON_LOW       8'h40
`define ADDR_ON_HIGH      8'h41
`define ADDR_PWM_CFG      8'h42
`define ADDR_DIV_CFG      8'h43
`define ADDR_LB1_CFG      8'h44
`define ADDR_LB2_CFG      8'h45
`define ADDR_FF_CTL       8'h46
`define PWM_EN_BIT        0
`define PWM_MODE_BIT      1
`define PWM_AND_BIT       2
`define DIV_EN_BIT        0
`define DIV_LSB           1
`define DIV_MSB           5
`define DIV_INV_BIT       6
`define LB_SEL_MSB        2
`define LB_A_INV_BIT      3
`define LB_B_INV_BIT      4
`define LB_C_INV_BIT      5
`define LB_Y_INV_BIT      6
`define LB_CHAIN_BIT      7
`define BLOCK1_FLOP_CLEAR_BIT       0
`define BLOCK1_FLOP_SET_BIT       1
`define BLOCK2_FLOP_CLEAR_BIT       2
`define BLOCK2_FLOP_SET_BIT       3
`define REG_RESET         8'h00
`define CLK_FREQ_KHZ      20000
`define TICK_FREQ_KHZ     500
// Oscillator steps on both edges: one 1 us count at the 500 kHz setting
`define TICK_DIV          (`CLK_FREQ_KHZ / (2 * `TICK_FREQ_KHZ))
`endif

// *** logic/aux_func_pkg.sv ***
package aux_func_pkg;
  typedef enum logic [2:0] {
    SEL_OFF, SEL_AND, SEL_OR, SEL_XOR, SEL_FLOP, SEL_A, SEL_B, SEL_C
  } lb_sel_t;
  typedef enum logic [1:0] {PWM_IDLE, PWM_ON, PWM_OFF} pwm_state_t;
  typedef struct packed {
    logic [7:0]  off_lo;
    logic [7:0]  off_hi;
    logic [7:0]  on_lo;
    logic [7:0]  on_hi;
    logic [15:0] on_act;
    logic [15:0] off_act;
    logic [7:0]  pwm_cfg;
    logic [7:0]  div_cfg;
    logic [7:0]  lb1_cfg;
    logic [7:0]  lb2_cfg;
    logic [7:0]  ff_ctl;
    logic        flop1;
    logic        flop2;
    pwm_state_t  pst;
    logic [15:0] pcnt;
    logic [5:0]  tick_cnt;
    logic [4:0]  dcnt;
    logic        dclk;
    logic        ext_prev;
    logic [1:0]  s_ext;
    logic [1:0]  s_col6;
    logic [1:0]  s_row0;
    logic [1:0]  s_a1;
    logic [1:0]  s_b1;
    logic [1:0]  s_c1;
    logic [1:0]  s_b2;
    logic [1:0]  s_c2;
    logic        pwm_q;
    logic        clk_q;
    logic        y1_q;
    logic        y2_q;
    logic        ack;
    logic [7:0]  dat;
  } state_t;
endpackage

// *** logic/aux_func.sv ***
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`include "aux_func_params.svh"
module aux_func (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic [7:0] adr_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]     dat_o,
  output logic            ack_o,
  input  wire logic       ext_clk_i,
  input  wire logic       column6_pin_i,
  input  wire logic       row_zero_pin_i,
  input  wire logic       block1_input_a_i,
  input  wire logic       block1_input_b_i,
  input  wire logic       block1_input_c_i,
  input  wire logic       block2_input_b_i,
  input  wire logic       block2_input_c_i,
  output logic            pwm_o,
  output logic            div_clk_o,
  output logic            block1_output_o,
  output logic            block2_output_o
);
  import aux_func_pkg::*;

  state_t r, n;

  function automatic logic lb_eval(input logic [7:0] cfg, input logic a,
                                   input logic b, input logic c,
                                   input logic flop);
    logic ai;
    logic bi;
    logic ci;
    logic y;
    ai = a ^ cfg[`LB_A_INV_BIT];
    bi = b ^ cfg[`LB_B_INV_BIT];
    ci = c ^ cfg[`LB_C_INV_BIT];
    case (lb_sel_t'(cfg[`LB_SEL_MSB:0]))
      SEL_AND:  y = ai & bi & ci;
      SEL_OR:   y = ai | bi | ci;
      SEL_XOR:  y = ai ^ bi ^ ci;
      SEL_FLOP: y = flop;
      SEL_A:    y = ai;
      SEL_B:    y = bi;
      SEL_C:    y = ci;
      default:  y = 1'b0;
    endcase
    // Select zero stays inactive even with output inversion
    if (cfg[`LB_SEL_MSB:0] == 3'b000) begin
      lb_eval = 1'b0;
    end else begin
      lb_eval = y ^ cfg[`LB_Y_INV_BIT];
    end
  endfunction

  logic       wr;
  logic       rd;
  logic       tick;
  logic       ext_rise;
  logic       y1;
  logic       y2;
  logic       a2;
  logic [7:0] wb;
  logic [5:0] dsum;
  logic [4:0] dhalf;

  always_comb begin
    n = r;
    wb = dat_i[7:0];
    wr = cyc_i & stb_i & we_i & ~r.ack & sel_i[0];
    rd = cyc_i & stb_i & ~we_i & ~r.ack;
    // Input synchronisers
    n.s_ext  = {r.s_ext[0], ext_clk_i};
    n.s_col6 = {r.s_col6[0], column6_pin_i};
    n.s_row0 = {r.s_row0[0], row_zero_pin_i};
    n.s_a1   = {r.s_a1[0], block1_input_a_i};
    n.s_b1   = {r.s_b1[0], block1_input_b_i};
    n.s_c1   = {r.s_c1[0], block1_input_c_i};
    n.s_b2   = {r.s_b2[0], block2_input_b_i};
    n.s_c2   = {r.s_c2[0], block2_input_c_i};

    // Wishbone slave: one wait state, ack for one cycle
    n.ack = cyc_i & stb_i & ~r.ack;
    n.dat = 8'h00;
    if (rd) begin
      if (adr_i == `ADDR_OFF_LOW) begin
        n.dat = r.off_lo;
      end else if (adr_i == `ADDR_OFF_HIGH) begin
        n.dat = r.off_hi;
      end else if (adr_i == `ADDR_ON_LOW) begin
        n.dat = r.on_lo;
      end else if (adr_i == `ADDR_ON_HIGH) begin
        n.dat = r.on_hi;
      end else if (adr_i == `ADDR_PWM_CFG) begin
        n.dat = {5'h00, r.pwm_cfg[2:0]};
      end else if (adr_i == `ADDR_DIV_CFG) begin
        n.dat = {1'b0, r.div_cfg[6:0]};
      end else if (adr_i == `ADDR_LB1_CFG) begin
        n.dat = {1'b0, r.lb1_cfg[6:0]};
      end else if (adr_i == `ADDR_LB2_CFG) begin
        n.dat = r.lb2_cfg;
      end else if (adr_i == `ADDR_FF_CTL) begin
        n.dat = {r.ff_ctl[7:4], 2'b00, r.flop2, r.flop1};
      end
    end

    // Block 1 and 2 logic from previous-cycle flop state
    y1 = lb_eval(r.lb1_cfg, r.s_a1[1], r.s_b1[1], r.s_c1[1], r.flop1);
    // Chained input replaces row 0 pin
    a2 = r.lb2_cfg[`LB_CHAIN_BIT] ? y1 : r.s_row0[1];
    y2 = lb_eval(r.lb2_cfg, a2, r.s_b2[1], r.s_c2[1], r.flop2);
    n.y1_q = y1;
    n.y2_q = y2;

    // Prescaler to oscillator tick
    tick = (r.tick_cnt == 6'(`TICK_DIV - 1));
    n.tick_cnt = tick ? 6'h00 : r.tick_cnt + 6'h01;

    // PWM sequencer counting ticks
    case (r.pst)
      PWM_IDLE: begin
        n.pwm_q = 1'b0;
        if (r.pwm_cfg[`PWM_EN_BIT] && r.on_act != 16'h0000) begin
          n.pst = PWM_ON;
          n.pcnt = r.on_act;
        end
      end
      PWM_ON: begin
        n.pwm_q = 1'b1;
        if (tick) begin
          if (r.pcnt <= 16'h0001) begin
            n.pst = PWM_OFF;
            n.pcnt = r.off_act;
            n.pwm_q = 1'b0;
          end else begin
            n.pcnt = r.pcnt - 16'h0001;
          end
        end
      end
      PWM_OFF: begin
        n.pwm_q = 1'b0;
        if (tick) begin
          if (r.pcnt <= 16'h0001) begin
            if (r.pwm_cfg[`PWM_MODE_BIT]) begin
              n.pst = PWM_IDLE;
              n.pwm_cfg[`PWM_EN_BIT] = 1'b0;
            end else begin
              n.pst = PWM_ON;
              n.pcnt = r.on_act;
              n.pwm_q = 1'b1;
            end
          end else begin
            n.pcnt = r.pcnt - 16'h0001;
          end
        end
      end
      default: n.pst = PWM_IDLE;
    endcase
    if (!r.pwm_cfg[`PWM_EN_BIT]) begin
      n.pst = PWM_IDLE;
      n.pwm_q = 1'b0;
    end
    if (r.pwm_cfg[`PWM_AND_BIT]) begin
      n.pwm_q = n.pwm_q & r.s_col6[1];
    end

    // Clock divider on external clock edges
    n.ext_prev = r.s_ext[1];
    ext_rise = r.s_ext[1] & ~r.ext_prev;
    // Six bits so that divide by 32 does not wrap to zero
    dsum = {1'b0, r.div_cfg[`DIV_MSB:`DIV_LSB]} + 6'h01;
    dhalf = dsum[5:1];
    if (!r.div_cfg[`DIV_EN_BIT]) begin
      n.dcnt = 5'h00;
      n.dclk = 1'b0;
    end else if (r.div_cfg[`DIV_MSB:`DIV_LSB] == 5'h00) begin
      n.dclk = r.s_ext[1];
    end else if (ext_rise) begin
      // Count rising edges; high for the first half of each output period
      if (r.dcnt == r.div_cfg[`DIV_MSB:`DIV_LSB]) begin
        n.dcnt = 5'h00;
      end else begin
        n.dcnt = r.dcnt + 5'h01;
      end
      if (r.dcnt == 5'h00) begin
        n.dclk = 1'b1;
      end else if (r.dcnt == dhalf) begin
        n.dclk = 1'b0;
      end
    end
    n.clk_q = (n.dclk ^ r.div_cfg[`DIV_INV_BIT]) & r.div_cfg[`DIV_EN_BIT];

    // Flop set/clear, set wins when both written
    if (wr && adr_i == `ADDR_FF_CTL) begin
      if (wb[`BLOCK1_FLOP_CLEAR_BIT]) n.flop1 = 1'b0;
      if (wb[`BLOCK1_FLOP_SET_BIT]) n.flop1 = 1'b1;
      if (wb[`BLOCK2_FLOP_CLEAR_BIT]) n.flop2 = 1'b0;
      if (wb[`BLOCK2_FLOP_SET_BIT]) n.flop2 = 1'b1;
      n.ff_ctl = {wb[7:4], 4'h0};
    end

    // Register writes
    if (wr) begin
      if (adr_i == `ADDR_OFF_LOW) begin
        n.off_lo = wb;
      end else if (adr_i == `ADDR_OFF_HIGH) begin
        n.off_hi = wb;
      end else if (adr_i == `ADDR_ON_LOW) begin
        n.on_lo = wb;
      end else if (adr_i == `ADDR_ON_HIGH) begin
        n.on_hi = wb;
        n.on_act = {wb, r.on_lo};
        n.off_act = {r.off_hi, r.off_lo};
      end else if (adr_i == `ADDR_PWM_CFG) begin
        n.pwm_cfg = {5'h00, wb[2:0]};
      end else if (adr_i == `ADDR_DIV_CFG) begin
        n.div_cfg = {1'b0, wb[6:0]};
      end else if (adr_i == `ADDR_LB1_CFG) begin
        n.lb1_cfg = {1'b0, wb[6:0]};
      end else if (adr_i == `ADDR_LB2_CFG) begin
        n.lb2_cfg = wb;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign dat_o = {24'h000000, r.dat};
  assign ack_o = r.ack;
  assign pwm_o = r.pwm_q;
  assign div_clk_o = r.clk_q;
  assign block1_output_o = r.y1_q;
  assign block2_output_o = r.y2_q;
endmodule

// *** tb/aux_func_sva.sv ***
`timescale 1ns/1ps
module aux_func_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  input wire logic        column6_pin_i,
  input wire logic        block1_input_a_i,
  input wire logic        pwm_o,
  input wire logic        div_clk_o,
  input wire logic        block1_output_o,
  input wire logic        block2_output_o
);
  logic [7:0] pc_r, dc_r, l1_r, l2_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Copies of the configuration bytes, loaded at the taking edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {pc_r, dc_r, l1_r, l2_r} <= 32'h0;
    end else if (cyc_i && stb_i && we_i && !ack_o && sel_i[0]) begin
      case (adr_i)
        8'h42: pc_r <= dat_i[7:0];
        8'h43: dc_r <= dat_i[7:0];
        8'h44: l1_r <= dat_i[7:0];
        8'h45: l2_r <= dat_i[7:0];
        default: ;
      endcase
    end
  end
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_off1; (l1_r[2:0] == 3'h0) [*2] |-> !block1_output_o; endproperty
  a_off1: assert property (p_off1) else $error("block1 on");
  property p_off2; (l2_r[2:0] == 3'h0) [*2] |-> !block2_output_o; endproperty
  a_off2: assert property (p_off2) else $error("block2 on");
  property p_divoff; (!dc_r[0]) [*3] |-> !div_clk_o; endproperty
  a_divoff: assert property (p_divoff) else $error("div runs");
  property p_pwmoff; (!pc_r[0]) [*3] |-> !pwm_o; endproperty
  a_pwmoff: assert property (p_pwmoff) else $error("pwm runs");
  property p_and; (pc_r[2] && !column6_pin_i) [*5] |-> !pwm_o; endproperty
  a_and: assert property (p_and) else $error("pwm not gated");
  property p_pass;
    (l1_r[2:0] == 3'h5 && block1_input_a_i) [*5]
      |-> block1_output_o == !(l1_r[3] ^ l1_r[6]);
  endproperty
  a_pass: assert property (p_pass) else $error("pass wrong");
  property p_chain;
    (l2_r[7] && l2_r[2:0] == 3'h5 && $stable(block1_output_o)) [*5]
      |-> block2_output_o == (block1_output_o ^ l2_r[3] ^ l2_r[6]);
  endproperty
  a_chain: assert property (p_chain) else $error("chain wrong");
  c_chain: cover property (l2_r[7] && block2_output_o);
  c_pwm: cover property ($rose(pwm_o));
  c_div: cover property (dc_r[6] && $rose(div_clk_o));
endmodule
bind aux_func aux_func_sva u_sva (.*);

// *** tb/pin_model.sv ***
`timescale 1ns/1ps
module pin_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] half_i,
  input  wire logic [6:0] lvl_i,
  output logic            ext_clk_o,
  output logic [6:0]      pin_o
);
  logic [7:0] cnt;
  initial begin
    {cnt, ext_clk_o, pin_o} = 16'h0;
  end
  // External clock toggles every half_i cycles, stands low at zero
  always @(posedge clk_i) begin
    pin_o <= lvl_i;
    cnt <= cnt + 8'h1;
    if (cnt == half_i) begin
      cnt <= 8'h1;
      ext_clk_o <= ~ext_clk_o;
    end
    if (half_i == 8'h0) ext_clk_o <= 1'b0;
  end
endmodule

// *** tb/test_pwm_clkdiv_logic_blocks.sv ***
`timescale 1ns/1ps
module test_pwm_clkdiv_logic_blocks;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, y1, y2, f1, f2;
  logic        ack_o, ext_clk, pwm_o, div_clk_o, b1_o, b2_o;
  logic [7:0]  adr_i, half, c1, c2, fc;
  logic [3:0]  sel_i;
  logic [6:0]  lvl, pin;
  logic [31:0] dat_i, dat_o, seed;
  logic [31:0] exp_q[$];
  logic [7:0]  dv [4] = '{8'h01, 8'h41, 8'h03, 8'h3f};
  int          mismatches, checks_done;
  time         t0;
  aux_func u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .ext_clk_i(ext_clk), .column6_pin_i(pin[0]),
    .row_zero_pin_i(pin[1]), .block1_input_a_i(pin[2]),
    .block1_input_b_i(pin[3]), .block1_input_c_i(pin[4]),
    .block2_input_b_i(pin[5]), .block2_input_c_i(pin[6]), .pwm_o,
    .div_clk_o, .block1_output_o(b1_o), .block2_output_o(b2_o));
  pin_model u_pins (.clk_i, .half_i(half), .lvl_i(lvl), .ext_clk_o(ext_clk),
    .pin_o(pin));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d, e,
                     input logic [3:0] s = 4'h1);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i} <= {2'b11, w, a, s};
    dat_i <= {24'h0, d};
    exp_q.push_back(w ? 32'h0 : {24'h0, e});
    do @(negedge clk_i); while (ack_o !== 1'b1);
    @(posedge clk_i);
    {cyc_i, stb_i} <= 2'b00;
  endtask
  always @(negedge clk_i) begin
    if (ack_o === 1'b1) chk("dat_o", dat_o, exp_q.pop_front());
  end
  function automatic logic lbf(input logic [7:0] c, input logic a, b, d, f);
    logic x, y, z;
    x = a ^ c[3];
    y = b ^ c[4];
    z = d ^ c[5];
    case (c[2:0])
      3'h0: return 1'b0;
      3'h1: return c[6] ^ (x & y & z);
      3'h2: return c[6] ^ (x | y | z);
      3'h3: return c[6] ^ x ^ y ^ z;
      3'h4: return c[6] ^ f;
      3'h5: return c[6] ^ x;
      3'h6: return c[6] ^ y;
      default: return c[6] ^ z;
    endcase
  endfunction
  task automatic pwchk(input int on, off);
    @(posedge pwm_o);
    @(posedge pwm_o);
    t0 = $time;
    @(negedge pwm_o);
    chk("on time", 32'($time - t0), on * 1000);
    @(posedge pwm_o);
    chk("period", 32'($time - t0), (on + off) * 1000);
  endtask
  initial begin
    seed = 32'h8be3c18f;
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, half, lvl, f1, f2} = '0;
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 8'h3e; a <= 8'h46; a++) bus(0, 8'(a), 0, 0);
    bus(1, 8'h50, 8'ha5, 0);
    bus(0, 8'h50, 0, 0);
    bus(1, 8'h45, 8'hff, 0, 4'he);
    bus(0, 8'h45, 0, 0);
    for (int i = 0; i < 48; i++) begin
      c1 = 8'($random(seed));
      c2 = 8'($random(seed));
      fc = 8'($random(seed));
      lvl <= 7'($random(seed));
      c1[7] = 1'b0;
      c1[2:0] = 3'(i);
      c2[2:0] = ~3'(i);
      bus(1, 8'h44, c1, 0);
      bus(1, 8'h45, c2, 0);
      bus(1, 8'h46, {4'h0, fc[3:0]}, 0);
      bus(0, 8'h45, 0, c2);
      f1 = fc[1] | (f1 & ~fc[0]);
      f2 = fc[3] | (f2 & ~fc[2]);
      repeat (6) @(negedge clk_i);
      y1 = lbf(c1, lvl[2], lvl[3], lvl[4], f1);
      y2 = lbf(c2, c2[7] ? y1 : lvl[1], lvl[5], lvl[6], f2);
      chk("block1", {31'h0, b1_o}, {31'h0, y1});
      chk("block2", {31'h0, b2_o}, {31'h0, y2});
    end
    bus(0, 8'h46, 0, {6'h0, f2, f1});
    half <= 8'd8;
    for (int k = 0; k < 4; k++) begin
      bus(1, 8'h43, dv[k], 0);
      @(posedge div_clk_o);
      @(posedge div_clk_o);
      t0 = $time;
      if (k < 2) chk("phase", {31'h0, ext_clk}, {31'h0, ~dv[k][6]});
      @(posedge div_clk_o);
      chk("div", 32'($time - t0), 800 * (dv[k][5:1] + 1));
    end
    bus(1, 8'h43, 8'h40, 0);
    repeat (40) @(negedge clk_i);
    chk("div off", {31'h0, div_clk_o}, 32'h0);
    half <= 8'd0;
    bus(1, 8'h3e, 8'h03, 0);
    bus(1, 8'h40, 8'h02, 0);
    bus(1, 8'h41, 8'h00, 0);
    bus(1, 8'h42, 8'h01, 0);
    pwchk(2, 3);
    bus(1, 8'h40, 8'h05, 0);
    pwchk(2, 3);
    bus(1, 8'h41, 8'h00, 0);
    pwchk(5, 3);
    bus(1, 8'h42, 8'h00, 0);
    for (int n = 0; n < 2; n++) begin
      bus(1, 8'h42, 8'h03, 0);
      @(negedge pwm_o);
      repeat (200) @(negedge clk_i);
      bus(0, 8'h42, 0, 8'h02);
    end
    bus(1, 8'h3f, 8'h01, 0);
    bus(1, 8'h3e, 8'h00, 0);
    bus(1, 8'h40, 8'h01, 0);
    bus(1, 8'h41, 8'h00, 0);
    bus(1, 8'h42, 8'h01, 0);
    pwchk(1, 256);
    lvl <= 7'h00;
    bus(1, 8'h42, 8'h05, 0);
    repeat (11000) @(negedge clk_i);
    lvl <= 7'h01;
    @(posedge pwm_o);
    @(negedge clk_i);
    chk("and", {31'h0, pwm_o}, 32'h1);
    wrap_up;
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    mismatches++;
    wrap_up;
  end
endmodule
